// [logic/sfc_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module sfc_fifo #(
  parameter int unsigned WIDTH = 17,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage; depth must be a power of two
  logic [AW-1:0] wr_ptr; // Next slot to fill
  logic [AW-1:0] rd_ptr; // Oldest slot
  logic [AW:0] count; // Words held
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr];

  // Occupancy after this cycle
  always_comb begin
    next_count = count;
    if (push && !pop) next_count = count + 1'b1;
    else if (pop && !push) next_count = count - 1'b1;
  end

  // Pointers and registered full/empty flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      count <= next_count;
      in_ready <= (next_count != FULL_CNT);
      out_valid <= (next_count != '0);
    end
  end

  // Data storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end
endmodule // sfc_fifo
`default_nettype wire

// [logic/sfc_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module sfc_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta; // First stage, read only by the second

  // Two flip-flops per bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= RST;
      q <= RST;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // sfc_sync
`default_nettype wire

// [logic/sfc_top.sv]
// Function
// - Sector write: opcode F3H plus sector field.
// - Byte address field, low nine bits, 0-107H.
// - Written data bytes overwrite SRAM buffer.
// - Bytes ascend, each byte MSB first.
// - Byte address increments, wraps after 107H.
// - Select rise copies SRAM, then programs sector.
// - Busy while programming; array commands ignored.
// - SRAM commands still work while busy.
// - SRAM-to-sector: F3H, no data, all bytes.
// - Sector-to-SRAM copies byte per eight clocks.
// - Output stays off during sector copy.
// - Sector copy wraps after 107H, ends trailing.
// - Compare outputs one for match, zero mismatch.
// - Compare starts at address, wraps after 107H.
// - Mismatch sets sticky compare flag.
// - Write-SRAM 82H loads SRAM, no array access.
// - Read-SRAM 81H reads SRAM, no array access.
// - Bits sampled on rising clock, select ends.
// - Read sequences send 9999H or 6666H word.
`timescale 1ns/1ps
`default_nettype none
module sfc_top #(
  parameter int unsigned PROG_CYCLES = sfc_pkg::PROG_CYCLES_DEF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  // Protection inputs
  input wire logic wp_pin,
  input wire logic write_enabled,
  input wire logic prot_en,
  input wire logic [sfc_pkg::SECT_W-1:0] prot_lo,
  input wire logic [sfc_pkg::SECT_W-1:0] prot_hi,
  // Status outputs
  output logic array_busy,
  output logic compare_mismatch_flag,
  // Array read port, data one cycle after the enable
  output logic arr_rd_en,
  output logic [sfc_pkg::SECT_W-1:0] arr_rd_sector,
  output logic [sfc_pkg::BYTE_W-1:0] arr_rd_byte,
  input wire logic [7:0] arr_rd_data,
  // Array program stream
  output logic arr_wr_valid,
  input wire logic arr_wr_ready,
  output logic [sfc_pkg::SECT_W-1:0] arr_wr_sector,
  output logic [sfc_pkg::BYTE_W-1:0] arr_wr_byte,
  output logic [7:0] arr_wr_data
);
  import sfc_pkg::*;

  logic sck_s, cs_n_s, si_s, wp_s; // Synchronised pins
  logic sck_d; // Previous serial clock level
  logic cs_d; // Previous select level
  logic sck_rise, sck_fall, cs_rise;
  logic [15:0] cnt; // Rising edges since select fell
  logic [15:0] next_cnt;
  logic [15:0] shreg; // Serial input shifter
  logic [15:0] next_sh;
  logic [7:0] opcode; // Current command
  logic busy_at_op; // Busy when the opcode completed
  logic [SECT_W-1:0] sector; // Addressed sector
  logic [BYTE_W-1:0] addr; // Running byte address
  logic [7:0] pend; // Byte waiting to enter the SRAM
  logic [BYTE_W-1:0] pend_addr;
  logic have_pend; // Pending byte is real
  logic rd_fetch; // Array data arrives this cycle
  logic [7:0] rd_byte; // SRAM byte being shifted out
  logic [7:0] cmp_byte; // Sector byte being compared
  logic [7:0] sram [BUF_BYTES]; // SRAM buffer
  logic [7:0] pbuf [BUF_BYTES]; // Program buffer
  logic is_wr, is_copy, is_rd, is_cmp, cmp_active;
  logic byte_edge; // Rising edge that completes a byte
  logic commit; // Pending byte written this cycle
  logic [2:0] bit_idx; // Bit of the byte on the output
  logic [3:0] rb_idx; // Bit of the ready/busy word
  logic [15:0] rb_word;
  logic wr_allowed; // Programming may start
  sfc_prog_state_t pstate;
  sfc_prog_state_t next_pstate;
  logic [BYTE_W-1:0] pidx; // Program buffer index
  logic [31:0] wait_cnt; // Program time elapsed
  logic fifo_in_ready;
  logic [PFIFO_WIDTH-1:0] fifo_out;
  logic fifo_out_valid;
  logic fifo_push;

  // Bring the pins into the clock domain
  sfc_sync #(.W(4), .RST(SYNC_RST)) u_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d({wp_pin, spi_si, spi_cs_n, spi_sck}),
    .q({wp_s, si_s, cs_n_s, sck_s})
  );

  // Edge detection on synchronised levels only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sck_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sck_d <= sck_s;
      cs_d <= cs_n_s;
    end
  end
  assign sck_rise = sck_s & ~sck_d & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_d & ~cs_n_s;
  assign cs_rise = cs_n_s & ~cs_d;

  // Counter rewinds to a byte-aligned value so bit positions stay right
  assign next_cnt = (cnt == CNT_MAX) ? CNT_REWIND : cnt + 16'h0001;
  assign next_sh = {shreg[14:0], si_s};
  assign byte_edge = sck_rise && (next_cnt[2:0] == 3'h0);

  // Command decode
  assign is_wr = (opcode == OP_WR_SECTOR) || (opcode == OP_WR_SRAM);
  assign is_copy = (opcode == OP_SECTOR_TO_SRAM) && !busy_at_op;
  assign is_rd = (opcode == OP_RD_SRAM);
  assign is_cmp = (opcode == OP_COMPARE);
  assign cmp_active = is_cmp && !busy_at_op;
  assign commit = byte_edge && have_pend && (is_wr || is_copy) && (next_cnt > CNT_FIRST_WR);

  // Bit counter and input shifter
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt <= '0;
      shreg <= '0;
    end else if (cs_n_s) begin
      cnt <= '0;
    end else if (sck_rise) begin
      cnt <= next_cnt;
      shreg <= next_sh;
    end
  end

  // Opcode and address fields, latched as each completes
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      opcode <= OP_NONE;
      busy_at_op <= 1'b0;
      sector <= '0;
    end else if (cs_n_s) begin
      opcode <= OP_NONE;
    end else if (sck_rise) begin
      if (next_cnt == CNT_OPCODE) begin
        opcode <= next_sh[7:0];
        busy_at_op <= array_busy;
      end
      // Upper sector bits are don't-care
      if (next_cnt == CNT_SECTOR) sector <= next_sh[SECT_W-1:0];
    end
  end

  // Byte address, pending byte and array fetches
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      addr <= '0;
      pend <= '0;
      pend_addr <= '0;
      have_pend <= 1'b0;
      rd_fetch <= 1'b0;
      rd_byte <= '0;
      cmp_byte <= '0;
      arr_rd_en <= 1'b0;
      arr_rd_sector <= '0;
      arr_rd_byte <= '0;
    end else begin
      arr_rd_en <= 1'b0;
      rd_fetch <= arr_rd_en;
      if (rd_fetch && is_copy) pend <= arr_rd_data;
      if (rd_fetch && cmp_active) cmp_byte <= arr_rd_data;
      if (cs_n_s) begin
        have_pend <= 1'b0;
      end else if (sck_rise && next_cnt == CNT_BADDR) begin
        // Out-of-range start address falls back to byte zero
        addr <= (next_sh[BYTE_W-1:0] > LAST_BYTE) ? FIRST_BYTE : next_sh[BYTE_W-1:0];
      end else if (byte_edge && next_cnt >= CNT_FIRST_WR && (is_wr || is_copy)) begin
        // Held one byte back so the trailing control byte is never stored
        pend_addr <= addr;
        have_pend <= 1'b1;
        addr <= (addr == LAST_BYTE) ? FIRST_BYTE : addr + 1'b1;
        if (is_wr) begin
          pend <= next_sh[7:0];
        end else begin
          // Serial input is not looked at here
          arr_rd_en <= 1'b1;
          arr_rd_sector <= sector;
          arr_rd_byte <= addr;
        end
      end else if (byte_edge && next_cnt >= CNT_DATA && (is_rd || cmp_active)) begin
        rd_byte <= sram[addr];
        addr <= (addr == LAST_BYTE) ? FIRST_BYTE : addr + 1'b1;
        if (cmp_active) begin
          arr_rd_en <= 1'b1;
          arr_rd_sector <= sector;
          arr_rd_byte <= addr;
        end
      end
    end
  end

  // SRAM write port, open even while the array is busy
  always_ff @(posedge sys_clk) begin
    if (commit) sram[pend_addr] <= pend;
  end

  // Serial output, changed on falling clock edges
  assign bit_idx = 3'h7 - cnt[2:0];
  assign rb_idx = 4'hF - 4'(cnt - CNT_RB);
  assign rb_word = busy_at_op ? RB_BUSY : RB_READY;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      spi_so <= 1'b0;
      spi_so_oe <= 1'b0;
    end else if (cs_n_s) begin
      spi_so_oe <= 1'b0;
    end else if (sck_fall) begin
      if (!(is_rd || is_cmp) || cnt < CNT_RB) begin
        // Write-type and copy commands keep the pin released
        spi_so_oe <= 1'b0;
      end else if (cnt < CNT_DATA) begin
        spi_so_oe <= 1'b1;
        spi_so <= rb_word[rb_idx];
      end else if (is_rd) begin
        spi_so_oe <= 1'b1;
        spi_so <= rd_byte[bit_idx];
      end else if (cmp_active) begin
        spi_so_oe <= 1'b1;
        spi_so <= ~(rd_byte[bit_idx] ^ cmp_byte[bit_idx]);
      end else begin
        // Busy compare ends after the status word
        spi_so_oe <= 1'b0;
      end
    end
  end

  // Sticky mismatch flag; a set wins over a same-cycle clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      compare_mismatch_flag <= 1'b0;
    end else if (sck_fall && cmp_active && cnt >= CNT_DATA &&
                 rd_byte[bit_idx] != cmp_byte[bit_idx]) begin
      compare_mismatch_flag <= 1'b1;
    end else if (cs_rise && opcode == OP_CLR_COMPARE) begin
      compare_mismatch_flag <= 1'b0;
    end
  end

  // Programming starts only when every protection is open
  assign wr_allowed = (opcode == OP_WR_SECTOR) && (cnt >= CNT_SECTOR) && !busy_at_op &&
                      wp_s && write_enabled &&
                      !(prot_en && sector >= prot_lo && sector <= prot_hi);

  // Program sequencer next state
  always_comb begin
    next_pstate = pstate;
    unique case (pstate)
      PS_IDLE: if (cs_rise && wr_allowed) next_pstate = PS_COPY;
      PS_COPY: if (pidx == LAST_BYTE) next_pstate = PS_FEED;
      PS_FEED: if (fifo_in_ready && pidx == LAST_BYTE) next_pstate = PS_WAIT;
      PS_WAIT: if (!fifo_out_valid && wait_cnt >= PROG_CYCLES) next_pstate = PS_IDLE;
    endcase
  end

  // Program sequencer registers; busy reported for the whole run
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pstate <= PS_IDLE;
      pidx <= '0;
      wait_cnt <= WAIT_RST;
      array_busy <= 1'b0;
      arr_wr_sector <= '0;
    end else begin
      pstate <= next_pstate;
      array_busy <= (next_pstate != PS_IDLE);
      if (pstate == PS_IDLE) begin
        pidx <= FIRST_BYTE;
        wait_cnt <= WAIT_RST;
        if (next_pstate == PS_COPY) arr_wr_sector <= sector;
      end else if (pstate == PS_COPY) begin
        pidx <= (pidx == LAST_BYTE) ? FIRST_BYTE : pidx + 1'b1;
      end else if (pstate == PS_FEED) begin
        if (fifo_in_ready) pidx <= pidx + 1'b1;
      end else if (!fifo_out_valid) begin
        // Program time runs once the last byte has left
        wait_cnt <= wait_cnt + 32'h0000_0001;
      end
    end
  end

  // Whole SRAM snapshot; takes 264 cycles, far shorter than any new write command
  always_ff @(posedge sys_clk) begin
    if (pstate == PS_COPY) pbuf[pidx] <= sram[pidx];
  end

  // Program stream, stalled by the array through the FIFO
  assign fifo_push = (pstate == PS_FEED);
  sfc_fifo #(.WIDTH(PFIFO_WIDTH), .DEPTH(PFIFO_DEPTH)) u_pfifo (
    .clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data({pidx, pbuf[pidx]}),
    .out_valid(fifo_out_valid),
    .out_ready(arr_wr_ready),
    .out_data(fifo_out)
  );
  assign arr_wr_valid = fifo_out_valid;
  assign arr_wr_byte = fifo_out[PFIFO_WIDTH-1:8];
  assign arr_wr_data = fifo_out[7:0];
endmodule // sfc_top
`default_nettype wire

// [pkg/sfc_pkg.sv]
`default_nettype none
package sfc_pkg;
  // Opcodes handled by this block
  localparam logic [7:0] OP_NONE = 8'h00;
  localparam logic [7:0] OP_WR_SECTOR = 8'hF3;
  localparam logic [7:0] OP_SECTOR_TO_SRAM = 8'h54;
  localparam logic [7:0] OP_COMPARE = 8'h86;
  localparam logic [7:0] OP_WR_SRAM = 8'h82;
  localparam logic [7:0] OP_RD_SRAM = 8'h81;
  localparam logic [7:0] OP_CLR_COMPARE = 8'h89;
  // Ready/busy words driven in read-type sequences
  localparam logic [15:0] RB_READY = 16'h9999;
  localparam logic [15:0] RB_BUSY = 16'h6666;
  // Buffer geometry
  localparam int unsigned BUF_BYTES = 264;
  localparam logic [8:0] LAST_BYTE = 9'h107;
  localparam logic [8:0] FIRST_BYTE = 9'h000;
  localparam int unsigned SECT_W = 11;
  localparam int unsigned BYTE_W = 9;
  // Serial clock counts at which each field is complete
  localparam logic [15:0] CNT_OPCODE = 16'h0008;
  localparam logic [15:0] CNT_SECTOR = 16'h0018;
  localparam logic [15:0] CNT_BADDR = 16'h0028;
  localparam logic [15:0] CNT_FIRST_WR = 16'h0030;
  localparam logic [15:0] CNT_RB = 16'h0038;
  localparam logic [15:0] CNT_DATA = 16'h0048;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_REWIND = 16'h0100;
  // Synchroniser reset value: {wp, si, cs_n, sck}, chip select idles high
  localparam logic [3:0] SYNC_RST = 4'h2;
  // Self-timed program time; figure is a plain default
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned PROG_TIME_NS = 1000;
  localparam int unsigned PROG_CYCLES_DEF = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [31:0] WAIT_RST = 32'h0000_0000;
  // Program FIFO shape
  localparam int unsigned PFIFO_WIDTH = 17;
  localparam int unsigned PFIFO_DEPTH = 32;
  // Program sequencer states
  typedef enum logic [1:0] {PS_IDLE, PS_COPY, PS_FEED, PS_WAIT} sfc_prog_state_t;
endpackage
`default_nettype wire

// [verification/sfc_array_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sfc_array_model (
  // Clock
  input wire logic sys_clk,
  // Read port
  input wire logic rd_en,
  input wire logic [10:0] rd_sector,
  input wire logic [8:0] rd_byte,
  output logic [7:0] rd_data,
  // Program stream
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [10:0] wr_sector,
  input wire logic [8:0] wr_byte,
  input wire logic [7:0] wr_data
);
  logic [7:0] mem [0:2111]; // Eight sectors only, low sector bits index
  logic [1:0] stall = 2'h0; // Stall one cycle in four
  int wr_count = 0; // Programmed bytes so far
  // Known pattern so reads can be predicted
  initial begin
    rd_data = 8'h00;
    for (int i = 0; i < 2112; i++) mem[i] = 8'(i / 264 * 31 + i % 264 * 7 + 1);
  end
  assign wr_ready = (stall != 2'h0);
  // Read data valid only one cycle after enable, else toggling junk
  always @(posedge sys_clk) begin
    stall <= stall + 2'h1;
    rd_data <= rd_en ? mem[rd_sector[2:0] * 264 + rd_byte] : ~rd_data;
    if (wr_valid && wr_ready) begin
      mem[wr_sector[2:0] * 264 + wr_byte] <= wr_data;
      wr_count <= wr_count + 1;
    end
  end
endmodule // sfc_array_model
`default_nettype wire

// [verification/sfc_top_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module sfc_top_assertions (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic spi_cs_n,
  input wire logic spi_so,
  input wire logic spi_so_oe,
  // Status
  input wire logic array_busy,
  input wire logic compare_mismatch_flag,
  // Array ports
  input wire logic arr_rd_en,
  input wire logic [sfc_pkg::BYTE_W-1:0] arr_rd_byte,
  input wire logic arr_wr_valid,
  input wire logic arr_wr_ready,
  input wire logic [sfc_pkg::SECT_W-1:0] arr_wr_sector,
  input wire logic [sfc_pkg::BYTE_W-1:0] arr_wr_byte,
  input wire logic [7:0] arr_wr_data
);
  import sfc_pkg::*;
  // One domain, so one default clock and disable
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_rd_pulse: assert property (arr_rd_en |=> !arr_rd_en)
    else $error("array read enable longer than one cycle");
  chk_rd_wrap: assert property (arr_rd_en |-> arr_rd_byte <= LAST_BYTE)
    else $error("array read byte past last byte");
  chk_wr_range: assert property (arr_wr_valid |-> arr_wr_byte <= LAST_BYTE)
    else $error("program byte past last byte");
  chk_wr_hold: assert property (arr_wr_valid && !arr_wr_ready |=>
    arr_wr_valid && $stable(arr_wr_byte) && $stable(arr_wr_data))
    else $error("program stream changed while stalled");
  chk_wr_busy: assert property (arr_wr_valid |-> array_busy)
    else $error("program stream outside busy");
  chk_no_rd_busy: assert property (arr_rd_en |-> !array_busy)
    else $error("array read while programming");
  chk_busy_start: assert property ($rose(array_busy) |-> spi_cs_n)
    else $error("busy began with select low");
  chk_sector_hold: assert property (array_busy [*2] |-> $stable(arr_wr_sector))
    else $error("program sector moved during run");
  chk_oe_idle: assert property (spi_cs_n [*4] |-> !spi_so_oe)
    else $error("output driven with select high");
  chk_flag_clear: assert property ($fell(compare_mismatch_flag) |-> spi_cs_n)
    else $error("mismatch flag dropped inside a command");
  chk_flag_set: assert property ($rose(compare_mismatch_flag) |->
    !spi_cs_n && spi_so_oe && !spi_so)
    else $error("mismatch flag set without a zero compare bit");
endmodule // sfc_top_assertions
bind sfc_top sfc_top_assertions sfc_top_assertions_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .spi_cs_n(spi_cs_n), .spi_so(spi_so), .spi_so_oe(spi_so_oe), .array_busy(array_busy),
  .compare_mismatch_flag(compare_mismatch_flag), .arr_rd_en(arr_rd_en),
  .arr_rd_byte(arr_rd_byte), .arr_wr_valid(arr_wr_valid), .arr_wr_ready(arr_wr_ready),
  .arr_wr_sector(arr_wr_sector), .arr_wr_byte(arr_wr_byte), .arr_wr_data(arr_wr_data));
`default_nettype wire

// [verification/sfc_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module sfc_top_tb;
  import sfc_pkg::*;
  // Long program time so SRAM reads fit inside busy
  localparam int unsigned PROG = 4000;
  logic sys_clk, rst_n, spi_sck, spi_cs_n, spi_si, wp_pin, write_enabled, prot_en;
  logic spi_so, spi_so_oe, array_busy, compare_mismatch_flag;
  logic [10:0] prot_lo, prot_hi, arr_rd_sector, arr_wr_sector;
  logic [8:0] arr_rd_byte, arr_wr_byte;
  logic [7:0] arr_rd_data, arr_wr_data;
  logic arr_rd_en, arr_wr_valid, arr_wr_ready;
  logic [7:0] tx [0:15];
  logic [7:0] rx [0:15];
  logic watch, oe_seen; // Output-enable monitor for write-type and sector-to-SRAM copy commands
  int n_errors, checks_done, base;
  sfc_top #(.PROG_CYCLES(PROG)) sfc_top_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so),
    .spi_so_oe(spi_so_oe), .wp_pin(wp_pin), .write_enabled(write_enabled),
    .prot_en(prot_en), .prot_lo(prot_lo), .prot_hi(prot_hi), .array_busy(array_busy),
    .compare_mismatch_flag(compare_mismatch_flag), .arr_rd_en(arr_rd_en),
    .arr_rd_sector(arr_rd_sector), .arr_rd_byte(arr_rd_byte), .arr_rd_data(arr_rd_data),
    .arr_wr_valid(arr_wr_valid), .arr_wr_ready(arr_wr_ready),
    .arr_wr_sector(arr_wr_sector), .arr_wr_byte(arr_wr_byte), .arr_wr_data(arr_wr_data));
  sfc_array_model sfc_array_model_i (.sys_clk(sys_clk), .rd_en(arr_rd_en),
    .rd_sector(arr_rd_sector), .rd_byte(arr_rd_byte), .rd_data(arr_rd_data),
    .wr_valid(arr_wr_valid), .wr_ready(arr_wr_ready), .wr_sector(arr_wr_sector),
    .wr_byte(arr_wr_byte), .wr_data(arr_wr_data));
  // 200 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Latch any output drive while watched
  always @(posedge sys_clk) if (watch && spi_so_oe === 1'b1) oe_seen <= 1'b1;
  function automatic logic [7:0] pat(input int s, input int b);
    return 8'(s * 31 + b * 7 + 1);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // One byte, MSB first; output sampled late in the low phase
  task automatic spi_byte(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      spi_si = b[i];
      spi_sck = 1'b0;
      tick(16);
      r[i] = spi_so;
      spi_sck = 1'b1;
      tick(16);
    end
  endtask
  // Opcode, sector, byte address, then nb bytes from tx into rx
  task automatic xfer(input logic [7:0] op, input logic [15:0] sec, input logic [15:0] ba,
                      input int nb);
    logic [7:0] junk;
    spi_cs_n = 1'b0;
    tick(4);
    spi_byte(op, junk);
    spi_byte(sec[15:8], junk);
    spi_byte(sec[7:0], junk);
    spi_byte(ba[15:8], junk);
    spi_byte(ba[7:0], junk);
    for (int i = 0; i < nb; i++) spi_byte(tx[i], rx[i]);
    spi_sck = 1'b0;
    tick(4);
    spi_cs_n = 1'b1;
    tick(8);
  endtask
  task automatic clr(input logic [7:0] v);
    for (int i = 0; i < 16; i++) tx[i] = v;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (array_busy !== 1'b0 && n < 10000) begin
      tick(1);
      n++;
    end
    if (n >= 10000) begin
      n_errors++;
      $display("ERROR at %0t: busy never ended", $time);
      report_and_stop();
    end
  endtask
  initial begin
    {spi_sck, spi_si, prot_en, watch, oe_seen, rst_n} = 6'h00;
    {spi_cs_n, wp_pin, write_enabled} = 3'h7;
    prot_lo = 11'h004;
    prot_hi = 11'h006;
    n_errors = 0;
    checks_done = 0;
    tick(20);
    rst_n = 1'b1;
    tick(8);
    // SRAM write across the wrap point, then read back
    clr(8'h00);
    {tx[0], tx[1], tx[2]} = 24'hA53CC3;
    watch = 1'b1;
    xfer(OP_WR_SRAM, 16'h0000, 16'h0106, 4);
    watch = 1'b0;
    check(oe_seen, 1'b0);
    clr(8'h00);
    xfer(OP_RD_SRAM, 16'h0000, 16'h0106, 7);
    check({rx[2], rx[3]}, RB_READY);
    check(rx[4], 8'hA5);
    check(rx[5], 8'h3C);
    check(rx[6], 8'hC3);
    $display("Test sram_wrap done");
    // Sector write, SRAM read during busy
    base = sfc_array_model_i.wr_count;
    {tx[0], tx[1]} = 16'h5A96;
    xfer(OP_WR_SECTOR, 16'h0005, 16'h0000, 3);
    check(array_busy, 1'b1);
    clr(8'h00);
    xfer(OP_RD_SRAM, 16'h0000, 16'h0000, 6);
    check({rx[2], rx[3]}, RB_BUSY);
    check(rx[4], 8'h5A);
    check(rx[5], 8'h96);
    wait_idle();
    check(sfc_array_model_i.wr_count - base, 264);
    check(sfc_array_model_i.mem[5 * 264], 8'h5A);
    check(sfc_array_model_i.mem[5 * 264 + 263], 8'h3C);
    $display("Test sector_write done");
    // SRAM to sector: no data, whole buffer programmed
    base = sfc_array_model_i.wr_count;
    // Select rises right after the 40 opcode, sector and address clocks; SRAM byte 0 must survive
    xfer(OP_WR_SECTOR, 16'h0006, 16'h0000, 0);
    wait_idle();
    check(sfc_array_model_i.wr_count - base, 264);
    check(sfc_array_model_i.mem[6 * 264], 8'h5A);
    check(sfc_array_model_i.mem[6 * 264 + 1], 8'h96);
    check(sfc_array_model_i.mem[6 * 264 + 262], 8'hA5);
    $display("Test sram_to_sector done");
    // Each protection cause blocks programming
    base = sfc_array_model_i.wr_count;
    for (int k = 0; k < 3; k++) begin
      wp_pin = (k != 0);
      write_enabled = (k != 1);
      prot_en = (k == 2);
      xfer(OP_WR_SECTOR, 16'h0005, 16'h0000, 2);
      tick(20);
      check(array_busy, 1'b0);
    end
    {wp_pin, write_enabled, prot_en} = 3'h6;
    check(sfc_array_model_i.wr_count - base, 0);
    $display("Test protection done");
    // Sector to SRAM across the wrap, input held at ones
    // Byte 1 is copied too: the trailing falling clock of a compare sees it
    clr(8'hFF);
    watch = 1'b1;
    xfer(OP_SECTOR_TO_SRAM, 16'h0002, 16'h0107, 4);
    watch = 1'b0;
    check(oe_seen, 1'b0);
    clr(8'h00);
    xfer(OP_RD_SRAM, 16'h0000, 16'h0107, 7);
    check(rx[4], pat(2, 263));
    check(rx[5], pat(2, 0));
    check(rx[6], pat(2, 1));
    $display("Test sector_to_sram done");
    // Compare: equal, then one nibble off, then clear
    clr(8'h00);
    xfer(OP_COMPARE, 16'h0002, 16'h0107, 6);
    check({rx[2], rx[3], rx[4], rx[5]}, {RB_READY, 16'hFFFF});
    check(compare_mismatch_flag, 1'b0);
    tx[0] = pat(2, 0) ^ 8'h0F;
    xfer(OP_WR_SRAM, 16'h0000, 16'h0000, 2);
    clr(8'h00);
    xfer(OP_COMPARE, 16'h0002, 16'h0107, 6);
    check({rx[4], rx[5]}, 16'hFFF0);
    check(compare_mismatch_flag, 1'b1);
    xfer(OP_COMPARE, 16'h0002, 16'h0107, 5);
    check(compare_mismatch_flag, 1'b1);
    xfer(OP_CLR_COMPARE, 16'h0000, 16'h0000, 0);
    check(compare_mismatch_flag, 1'b0);
    $display("Test compare done");
    report_and_stop();
  end
endmodule // sfc_top_tb
`default_nettype wire
